// File: pkg/sss_consts.vh
/*
  Constants of the safe stop sequencer: register offsets, field
  positions, reset values and timing figures.
  Assumes a 250 MHz mclk and byte addresses on an AXI4-Lite bus.
*/
`ifndef SSS_CONSTS_VH
`define SSS_CONSTS_VH

// Register byte offsets
`define SSS_REG_CTRL 8'h00
`define SSS_REG_TIME_STOP_DELAY 8'h04
`define SSS_REG_ZERO_EXTRA_DELAY 8'h08
`define SSS_REG_ZERO_NO_ENC 8'h0C
`define SSS_REG_ZERO_ENC 8'h10
`define SSS_REG_BRAKE_THRESHOLD 8'h14
`define SSS_REG_BRAKE_TORQUE_DELAY 8'h18
`define SSS_REG_BRAKE_STANDSTILL 8'h1C
`define SSS_REG_STATUS 8'h20
`define SSS_REG_FAULT 8'h24

// Control register fields
`define SSS_CTRL_VER_LSB 0
`define SSS_CTRL_VER_MSB 1
`define SSS_CTRL_VARIANT 2
`define SSS_CTRL_AUTO_ACK 3
`define SSS_CTRL_FB_NC 4
`define SSS_CTRL_DIAG_A 5
`define SSS_CTRL_DIAG_B 6
`define SSS_CTRL_ENCODER 7
`define SSS_CTRL_FAULT_REACT 8
`define SSS_CTRL_ACK 9

// Fault register fields
`define SSS_FAULT_BRAKE 0
`define SSS_FAULT_MISMATCH 1

// Reset values
`define SSS_RST_CTRL 9'h178
`define SSS_RST_TIME_STOP_DELAY 16'h07D0
`define SSS_RST_ZERO_EXTRA_DELAY 16'h0000
`define SSS_RST_ZERO_NO_ENC 16'h005A
`define SSS_RST_ZERO_ENC 16'h005A
`define SSS_RST_BRAKE_THRESHOLD 16'h0000
`define SSS_RST_BRAKE_TORQUE_DELAY 16'h0000
`define SSS_RST_BRAKE_STANDSTILL 16'h04B0

// Timing
`define SSS_CLK_PERIOD_NS 4
`define SSS_TICK_PERIOD_NS 1000000
`define SSS_DIAG_PERIOD_MS 16'h0064
`define SSS_DIAG_PULSE_NS 1000
`define SSS_FB_FILTER_MS 16'h000A

`endif

// File: hdl/sss_pin_sync.v
/*
  Three-stage synchroniser for a group of pins.
  Assumes pins are asynchronous to mclk; a change is accepted once the
  second and third stages agree.
*/
`timescale 1ns/1ns
`default_nettype none

module sss_pin_sync #(
  parameter W = 1,
  parameter [W-1:0] RESET_VAL = {W{1'b0}}
) (
  // Clock and reset
  input wire mclk,
  input wire rst_n,
  // Pins and clean levels
  input wire [W-1:0] pin,
  output reg [W-1:0] level
);

  reg [W-1:0] s1;
  reg [W-1:0] s2;
  reg [W-1:0] s3;

  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      always @(posedge mclk) begin
        if (!rst_n) begin
          s1[i] <= RESET_VAL[i];
          s2[i] <= RESET_VAL[i];
          s3[i] <= RESET_VAL[i];
          level[i] <= RESET_VAL[i];
        end else begin
          s1[i] <= pin[i];
          s2[i] <= s1[i];
          s3[i] <= s2[i];
          if (s2[i] == s3[i]) begin
            level[i] <= s3[i];
          end
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// File: hdl/sss_top.v
/*
  Safe stop sequencer: emergency ramp, timed or speed triggered torque
  removal, redundant pulse-tested brake with feedback check, AXI4-Lite
  registers.
  Assumes motor_speed and monitor_limit_hit come from logic on mclk;
  stop and feedback inputs are pins.
*/
// Functional notes
// RULE_01 - Stop sequence runs only when the enable version is active.
// RULE_02 - Variant bit picks time-monitored or ramp-monitored stop.
// RULE_03 - Every stop request while enabled commands the emergency deceleration ramp.
// RULE_04 - Time variant removes torque once the stop delay elapses.
// RULE_05 - Speed below zero-speed limit completes stop and removes torque.
// RULE_06 - Separate zero limits with and without encoder; use the matching.
// RULE_07 - Extra delay, possibly zero, after speed limit before torque off.
// RULE_08 - Brake speed threshold of zero disables speed-triggered brake.
// RULE_09 - Below brake threshold the brake engages and torque is removed.
// RULE_10 - Zero brake delay drives brake and torque removal together.
// RULE_11 - Without encoder, braked stop completes after standstill time.
// RULE_12 - Brake drives two redundant outputs with test pulses.
// RULE_13 - Brake feedback disagreement is a fault removing torque.
// RULE_14 - Linked NC feedback reads inverse of the relay command.
// RULE_15 - Stop request arrives as a redundant pair of inputs.
// RULE_16 - Automatic acknowledge needs no external acknowledge.
// RULE_17 - One single-channel output shows the stop function state.
// RULE_18 - Brake enable carries to emergency stop, not to torque-off.
// RULE_19 - Monitoring limit violation removes torque immediately.
// RULE_20 - Speed-triggered brake delay is negative: brake first.
// RULE_21 - Positive brake delay engages brake after torque removal.
// RULE_22 - Delays timed by millisecond counter, cleared per new sequence.
// RULE_23 - Disagreeing stop channels count as a stop request.
`timescale 1ns/1ns
`default_nettype none
`include "sss_consts.vh"

module sss_top #(
  parameter MS_TICK_CYCLES = `SSS_TICK_PERIOD_NS / `SSS_CLK_PERIOD_NS
) (
  // Clock and reset
  input wire mclk,
  input wire rst_n,
  // AXI4-Lite slave
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Pins: stop pair (low = stop) and brake feedback
  input wire stop_request_input_a,
  input wire stop_request_input_b,
  input wire relay_feedback_input,
  // Drive side
  input wire [15:0] motor_speed,
  input wire monitor_limit_hit,
  output reg emergency_decel_ramp,
  output reg torque_removal,
  output reg emergency_stop_brake_enable,
  // Brake relay and state output
  output reg brake_out_a,
  output reg brake_out_b,
  output reg stop_state_output
);

  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_RAMP = 3'h1;
  localparam [2:0] S_EXTRA = 3'h2;
  localparam [2:0] S_LEAD = 3'h3;
  localparam [2:0] S_OFF = 3'h4;
  localparam [31:0] TICK_LAST_W = MS_TICK_CYCLES - 1;
  localparam [19:0] TICK_LAST = TICK_LAST_W[19:0];
  localparam [31:0] PULSE_CYC_W =
    (`SSS_DIAG_PULSE_NS + `SSS_CLK_PERIOD_NS - 1) / `SSS_CLK_PERIOD_NS;
  localparam [8:0] PULSE_CYC = PULSE_CYC_W[8:0];
  localparam [15:0] DIAG_HALF = `SSS_DIAG_PERIOD_MS >> 1;

  // Registers
  reg [9:0] ctrl;
  reg [15:0] time_stop_delay;
  reg [15:0] zero_speed_extra_delay;
  reg [15:0] zero_speed_no_encoder;
  reg [15:0] zero_speed_encoder;
  reg [15:0] brake_speed_threshold;
  reg [15:0] brake_torque_delay;
  reg [15:0] brake_time_to_standstill;
  reg brake_fault;
  reg chan_mismatch;
  reg ack_pulse;

  // Sequencer state
  reg [2:0] state;
  reg [15:0] seq_ms;
  reg [15:0] brake_ms;
  reg [15:0] fb_ms;
  reg [15:0] diag_ms;
  reg [19:0] tick_cnt;
  reg tick;
  reg [8:0] pulse_left;
  reg pulse_b;
  reg brake_cmd;
  reg complete;
  reg acked;

  // Synchronised pins
  wire [2:0] pins_s;
  sss_pin_sync #(.W(3), .RESET_VAL(3'h7)) u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .pin({relay_feedback_input, stop_request_input_b, stop_request_input_a}),
    .level(pins_s)
  );

  wire stop_req = ~pins_s[0] | ~pins_s[1]; // RULE_15 RULE_23
  wire enabled = |ctrl[`SSS_CTRL_VER_MSB:`SSS_CTRL_VER_LSB]; // RULE_01
  wire ramp_variant = ctrl[`SSS_CTRL_VARIANT]; // RULE_02
  wire enc_used = ctrl[`SSS_CTRL_ENCODER];
  wire brake_en = |brake_speed_threshold; // RULE_08
  wire [15:0] zero_lim = enc_used ? zero_speed_encoder
                                  : zero_speed_no_encoder; // RULE_06
  wire below_zero = motor_speed < zero_lim; // RULE_05
  wire below_brake = brake_en & (motor_speed < brake_speed_threshold);
  wire trig = brake_en ? below_brake : below_zero; // RULE_09
  wire dly_neg = brake_torque_delay[15];
  wire [15:0] dly_mag = dly_neg ? (16'h0000 - brake_torque_delay)
                                : brake_torque_delay;
  wire relay_on = ~brake_cmd;
  wire fb_expect = ctrl[`SSS_CTRL_FB_NC] ? ~relay_on : relay_on; // RULE_14
  wire fb_bad = pins_s[2] != fb_expect;
  wire forced_off = brake_fault & ctrl[`SSS_CTRL_FAULT_REACT];

  // Millisecond tick
  always @(posedge mclk) begin
    if (!rst_n) begin
      tick_cnt <= 20'h00000;
      tick <= 1'b0;
    end else begin
      tick <= (tick_cnt == TICK_LAST);
      tick_cnt <= (tick_cnt == TICK_LAST) ? 20'h00000 : tick_cnt + 20'h00001;
    end
  end

  // Stop sequence
  always @(posedge mclk) begin
    if (!rst_n) begin
      state <= S_IDLE;
      seq_ms <= 16'h0000;
      brake_ms <= 16'h0000;
      brake_cmd <= 1'b0;
      complete <= 1'b0;
      acked <= 1'b0;
    end else begin
      if (tick && seq_ms != 16'hFFFF) begin
        seq_ms <= seq_ms + 16'h0001;
      end
      if (tick && brake_cmd && brake_ms != 16'hFFFF) begin
        brake_ms <= brake_ms + 16'h0001;
      end
      case (state)
        S_IDLE: begin
          if (stop_req && enabled) begin // RULE_01
            state <= S_RAMP;
            seq_ms <= 16'h0000; // RULE_22
            brake_ms <= 16'h0000;
            complete <= 1'b0;
            acked <= 1'b0;
          end
        end
        S_RAMP: begin
          if (monitor_limit_hit ||
              (!ramp_variant && seq_ms >= time_stop_delay)) begin // RULE_04
            state <= S_OFF; // RULE_19
            seq_ms <= 16'h0000;
            if (brake_en && (dly_neg || dly_mag == 16'h0000)) begin
              brake_cmd <= 1'b1;
            end
          end else if (trig) begin
            state <= S_EXTRA;
            seq_ms <= 16'h0000;
          end
        end
        S_EXTRA: begin
          if (monitor_limit_hit) begin
            state <= S_OFF; // RULE_19
            seq_ms <= 16'h0000;
          end else if (seq_ms >= zero_speed_extra_delay) begin // RULE_07
            seq_ms <= 16'h0000;
            if (brake_en && (dly_neg || dly_mag == 16'h0000)) begin
              brake_cmd <= 1'b1; // RULE_09 RULE_20
            end
            if (brake_en && dly_neg && dly_mag != 16'h0000) begin
              state <= S_LEAD; // RULE_20
            end else begin
              state <= S_OFF; // RULE_10
            end
          end
        end
        S_LEAD: begin
          if (monitor_limit_hit || seq_ms >= dly_mag) begin
            state <= S_OFF;
            seq_ms <= 16'h0000;
          end
        end
        S_OFF: begin
          if (brake_en && !brake_cmd && !dly_neg && seq_ms >= dly_mag) begin
            brake_cmd <= 1'b1; // RULE_21
          end
          if (!enc_used && brake_cmd) begin
            complete <= brake_ms >= brake_time_to_standstill; // RULE_11
          end else begin
            complete <= below_zero; // RULE_05
          end
          if (complete && (ctrl[`SSS_CTRL_AUTO_ACK] || ack_pulse)) begin
            acked <= 1'b1; // RULE_16
          end
          if (acked && !stop_req) begin
            state <= S_IDLE;
            brake_cmd <= 1'b0;
            complete <= 1'b0;
            acked <= 1'b0;
          end
        end
        default: begin
          state <= S_OFF;
        end
      endcase
    end
  end

  // Brake test pulses and feedback check
  always @(posedge mclk) begin
    if (!rst_n) begin
      diag_ms <= 16'h0000;
      pulse_left <= 9'h000;
      pulse_b <= 1'b0;
      fb_ms <= 16'h0000;
    end else begin
      if (tick) begin
        diag_ms <= (diag_ms == `SSS_DIAG_PERIOD_MS - 16'h0001) ? 16'h0000
                   : diag_ms + 16'h0001;
      end
      if (tick && (diag_ms == 16'h0000 || diag_ms == DIAG_HALF)) begin
        pulse_left <= PULSE_CYC;
        pulse_b <= (diag_ms == DIAG_HALF);
      end else if (pulse_left != 9'h000) begin
        pulse_left <= pulse_left - 9'h001;
      end
      if (!fb_bad) begin
        fb_ms <= 16'h0000;
      end else if (tick && fb_ms != 16'hFFFF) begin
        fb_ms <= fb_ms + 16'h0001;
      end
    end
  end

  // Registered outputs
  always @(posedge mclk) begin
    if (!rst_n) begin
      emergency_decel_ramp <= 1'b0;
      torque_removal <= 1'b0;
      emergency_stop_brake_enable <= 1'b0;
      brake_out_a <= 1'b0;
      brake_out_b <= 1'b0;
      stop_state_output <= 1'b0;
    end else begin
      emergency_decel_ramp <= state != S_IDLE; // RULE_03
      torque_removal <= (state == S_OFF) | forced_off; // RULE_13
      emergency_stop_brake_enable <= brake_en; // RULE_18
      brake_out_a <= relay_on & ~(ctrl[`SSS_CTRL_DIAG_A] &
                     (pulse_left != 9'h000) & ~pulse_b); // RULE_12
      brake_out_b <= relay_on & ~(ctrl[`SSS_CTRL_DIAG_B] &
                     (pulse_left != 9'h000) & pulse_b); // RULE_12
      stop_state_output <= state != S_IDLE; // RULE_17
    end
  end

  // AXI4-Lite write path
  reg aw_full;
  reg w_full;
  reg [7:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire do_write = aw_full & w_full & ~s_axi_bvalid;
  wire aw_full_next = do_write ? 1'b0 : (aw_full | aw_take);
  wire w_full_next = do_write ? 1'b0 : (w_full | w_take);
  wire [31:0] wmask = {{8{w_strb[3]}}, {8{w_strb[2]}},
                       {8{w_strb[1]}}, {8{w_strb[0]}}};
  wire [31:0] wbits = w_data & wmask;
  wire wr_fault = do_write && aw_addr == `SSS_REG_FAULT;
  wire wr_hit = aw_addr <= `SSS_REG_FAULT && aw_addr[1:0] == 2'h0;

  function [15:0] merge16;
    input [15:0] old;
    input [31:0] data;
    input [3:0] strb;
    begin
      merge16 = {strb[1] ? data[15:8] : old[15:8],
                 strb[0] ? data[7:0] : old[7:0]};
    end
  endfunction

  wire [15:0] ctrl_merged = merge16({7'h00, ctrl[8:0]}, w_data, w_strb);

  always @(posedge mclk) begin
    if (!rst_n) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      ctrl <= {1'b0, `SSS_RST_CTRL};
      time_stop_delay <= `SSS_RST_TIME_STOP_DELAY;
      zero_speed_extra_delay <= `SSS_RST_ZERO_EXTRA_DELAY;
      zero_speed_no_encoder <= `SSS_RST_ZERO_NO_ENC;
      zero_speed_encoder <= `SSS_RST_ZERO_ENC;
      brake_speed_threshold <= `SSS_RST_BRAKE_THRESHOLD;
      brake_torque_delay <= `SSS_RST_BRAKE_TORQUE_DELAY;
      brake_time_to_standstill <= `SSS_RST_BRAKE_STANDSTILL;
      ack_pulse <= 1'b0;
    end else begin
      aw_full <= aw_full_next;
      w_full <= w_full_next;
      s_axi_awready <= ~aw_full_next;
      s_axi_wready <= ~w_full_next;
      if (aw_take) begin
        aw_addr <= s_axi_awaddr;
      end
      if (w_take) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      ack_pulse <= do_write && aw_addr == `SSS_REG_CTRL &&
                   wbits[`SSS_CTRL_ACK];
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? 2'h0 : 2'h2;
        case (aw_addr)
          `SSS_REG_CTRL: ctrl[8:0] <= ctrl_merged[8:0];
          `SSS_REG_TIME_STOP_DELAY: time_stop_delay <=
            merge16(time_stop_delay, w_data, w_strb);
          `SSS_REG_ZERO_EXTRA_DELAY: zero_speed_extra_delay <=
            merge16(zero_speed_extra_delay, w_data, w_strb);
          `SSS_REG_ZERO_NO_ENC: zero_speed_no_encoder <=
            merge16(zero_speed_no_encoder, w_data, w_strb);
          `SSS_REG_ZERO_ENC: zero_speed_encoder <=
            merge16(zero_speed_encoder, w_data, w_strb);
          `SSS_REG_BRAKE_THRESHOLD: brake_speed_threshold <=
            merge16(brake_speed_threshold, w_data, w_strb);
          `SSS_REG_BRAKE_TORQUE_DELAY: brake_torque_delay <=
            merge16(brake_torque_delay, w_data, w_strb);
          `SSS_REG_BRAKE_STANDSTILL: brake_time_to_standstill <=
            merge16(brake_time_to_standstill, w_data, w_strb);
          default: ctrl[9] <= 1'b0;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Sticky faults, set wins over write-one-to-clear
  always @(posedge mclk) begin
    if (!rst_n) begin
      brake_fault <= 1'b0;
      chan_mismatch <= 1'b0;
    end else begin
      brake_fault <= (fb_ms >= `SSS_FB_FILTER_MS) | (brake_fault & // RULE_13
        ~(wr_fault & wbits[`SSS_FAULT_BRAKE]));
      chan_mismatch <= (pins_s[0] != pins_s[1]) | (chan_mismatch & // RULE_23
        ~(wr_fault & wbits[`SSS_FAULT_MISMATCH]));
    end
  end

  // AXI4-Lite read path
  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h00000000;
    case (s_axi_araddr)
      `SSS_REG_CTRL: rd_mux = {23'h000000, ctrl[8:0]};
      `SSS_REG_TIME_STOP_DELAY: rd_mux = {16'h0000, time_stop_delay};
      `SSS_REG_ZERO_EXTRA_DELAY: rd_mux = {16'h0000, zero_speed_extra_delay};
      `SSS_REG_ZERO_NO_ENC: rd_mux = {16'h0000, zero_speed_no_encoder};
      `SSS_REG_ZERO_ENC: rd_mux = {16'h0000, zero_speed_encoder};
      `SSS_REG_BRAKE_THRESHOLD: rd_mux = {16'h0000, brake_speed_threshold};
      `SSS_REG_BRAKE_TORQUE_DELAY: rd_mux = {16'h0000, brake_torque_delay};
      `SSS_REG_BRAKE_STANDSTILL: rd_mux = {16'h0000,
                                           brake_time_to_standstill};
      `SSS_REG_STATUS: rd_mux = {23'h000000, stop_req, acked, complete,
                                 emergency_decel_ramp, brake_cmd,
                                 torque_removal, state};
      `SSS_REG_FAULT: rd_mux = {30'h00000000, chan_mismatch, brake_fault};
      default: rd_mux = 32'h00000000;
    endcase
  end

  wire rd_hit = s_axi_araddr <= `SSS_REG_FAULT && s_axi_araddr[1:0] == 2'h0;

  always @(posedge mclk) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_hit ? 2'h0 : 2'h2;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

endmodule

`default_nettype wire

// File: tb/sss_top_monitor.sv
/* Port checker for sss_top, bound from the bench top.
   Assumes stop pins stay low while a request stands. */
`timescale 1ns/1ns
`default_nettype none
module sss_top_monitor #(
  parameter MS_TICK_CYCLES = 10
) (
  // Clock and reset
  input wire mclk,
  input wire rst_n,
  // Bus handshakes
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  // Sequencer
  input wire stop_request_input_a,
  input wire stop_request_input_b,
  input wire monitor_limit_hit,
  input wire emergency_decel_ramp,
  input wire torque_removal,
  input wire brake_out_a,
  input wire brake_out_b,
  input wire stop_state_output
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  ramp_state_a: assert property (
    $rose(emergency_decel_ramp) |-> $rose(stop_state_output))
    else $error("ramp rose without stop state");
  ramp_cause_a: assert property (
    $rose(emergency_decel_ramp) |-> !stop_request_input_a ||
    !stop_request_input_b) else $error("ramp without stop pin");
  limit_hit_a: assert property (
    stop_state_output && !torque_removal && monitor_limit_hit |->
    ##[1:3] torque_removal) else $error("limit hit kept torque");
  pulse_len_a: assert property (
    $rose(brake_out_a) && brake_out_b && $past(brake_out_b) |->
    !$past(brake_out_a, 250)) else $error("test pulse length wrong");
  torque_hold_a: assert property (
    $fell(torque_removal) |-> stop_request_input_a &&
    stop_request_input_b) else $error("torque back during request");
  state_end_a: assert property (
    $fell(stop_state_output) |-> $past(torque_removal))
    else $error("stop ended before torque off");
  wr_answer_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |->
    ##2 s_axi_bvalid) else $error("write answer late");
  rd_answer_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
endmodule
`default_nettype wire

// File: tb/sss_drive_model.sv
/* Drive and brake relay stand-in for the sequencer bench.
   Speed falls one rpm a cycle while the ramp is on. */
`timescale 1ns/1ns
`default_nettype none
module sss_drive_model (
  // Clock
  input wire mclk,
  // Speed
  input wire load,
  input wire [15:0] load_val,
  input wire ramp,
  output logic [15:0] speed,
  // Brake relay
  input wire brake_a,
  input wire brake_b,
  input wire fb_wrong,
  output wire fb
);
  always @(posedge mclk) begin
    if (load)
      speed <= load_val;
    else if (ramp && speed != 16'h0000)
      speed <= speed - 16'h0001;
  end
  // Relay holds through a single-channel pulse
  assign fb = ~(brake_a | brake_b) ^ fb_wrong;
endmodule
`default_nettype wire

// File: tb/sss_top_tb_top.sv
/* Bench for sss_top with a 10-cycle ms tick.
   Assumes sss_drive_model stands for motor and brake relay. */
`timescale 1ns/1ns
`default_nettype none
module sss_top_tb_top;
  // Block inputs
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, monitor_limit_hit = 1'b0;
  logic stop_request_input_a = 1'b1, stop_request_input_b = 1'b1;
  logic load = 1'b1, fb_bad = 1'b0;
  logic [15:0] load_val = 16'h0000;
  // Block outputs
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire s_axi_rvalid, relay_feedback_input, emergency_decel_ramp;
  wire torque_removal, emergency_stop_brake_enable, brake_out_a;
  wire brake_out_b, stop_state_output;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [15:0] motor_speed;
  integer bad_count = 0, checks = 0, cyc = 0, n = 0;
  logic [31:0] d;
  logic [1:0] r;
  sss_top #(.MS_TICK_CYCLES(10)) sss_top_i (.*);
  sss_drive_model sss_drive_model_i (.mclk(mclk), .load(load),
    .load_val(load_val), .ramp(emergency_decel_ramp), .speed(motor_speed),
    .brake_a(brake_out_a), .brake_b(brake_out_b), .fb_wrong(fb_bad),
    .fb(relay_feedback_input));
  always #2 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count = bad_count + 1;
      wrap_up;
    end
  end
  task wrap_up;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input [31:0] exp, input [31:0] got, input [63:0] what);
    checks = checks + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("MISMATCH %0s exp %0h got %0h", what, exp, got);
    end
  endtask
  task wr(input [7:0] a, input [31:0] v);
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task rd(input [7:0] a);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task pins(input a, input b);
    @(posedge mclk);
    stop_request_input_a <= a;
    stop_request_input_b <= b;
  endtask
  task spd(input [15:0] v);
    @(posedge mclk);
    load <= 1'b1;
    load_val <= v;
    @(posedge mclk);
    load <= 1'b0;
  endtask
  // Bounded wait: 0 torque off, 1 ramp on, 2 stop state gone
  task wt(input integer s);
    n = 0;
    while (n < 3000 && (s == 0 ? torque_removal : s == 1 ?
        emergency_decel_ramp : !stop_state_output) !== 1'b1) begin
      @(posedge mclk);
      n = n + 1;
    end
  endtask
  task idle;
    spd(16'h0000);
    pins(1'b1, 1'b1);
    wt(2);
    repeat (3) @(posedge mclk);
    chk(32'h0, torque_removal, "tq_idle");
  endtask
  task t_regs;
    rd(8'h00);
    chk(32'h178, d, "ctrl");
    rd(8'h28);
    chk(32'h2, r, "rresp");
    chk(32'h0, d, "rdata");
    wr(8'h28, 32'h1);
    chk(32'h2, r, "bresp");
    wr(8'h20, 32'hFF);
    chk(32'h0, r, "ro_resp");
    pins(1'b0, 1'b0);
    repeat (40) @(posedge mclk);
    chk(32'h0, emergency_decel_ramp, "ramp_off");
    pins(1'b1, 1'b1);
    repeat (10) @(posedge mclk);
    $display("t_regs done");
  endtask
  task t_time;
    wr(8'h04, 32'h5);
    wr(8'h00, 32'h1F9);
    repeat (2) begin
      spd(16'h0BB8);
      pins(1'b0, 1'b0);
      wt(1);
      chk(32'h1, stop_state_output, "state");
      chk(32'h0, torque_removal, "tq_early");
      wt(0);
      chk(32'h1, n >= 35 && n <= 65, "tq_time");
      idle;
    end
    $display("t_time done");
  endtask
  task t_ramp;
    wr(8'h0C, 32'h1F4);
    wr(8'h08, 32'h3);
    wr(8'h00, 32'h1FD);
    spd(16'h00C8);
    pins(1'b0, 1'b0);
    wt(0);
    chk(32'h1, motor_speed < 16'h5A, "spd_zero");
    chk(32'h1, motor_speed >= 16'h30, "spd_xtra");
    idle;
    $display("t_ramp done");
  endtask
  task t_brake;
    wr(8'h08, 32'h0);
    wr(8'h14, 32'hB4);
    repeat (2) @(posedge mclk);
    chk(32'h1, emergency_stop_brake_enable, "esbe");
    spd(16'h0190);
    pins(1'b0, 1'b0);
    wt(0);
    chk(32'h0, {brake_out_a, brake_out_b}, "brake");
    chk(32'h1, motor_speed >= 16'hA5 && motor_speed < 16'hB4, "spd_brk");
    repeat (150) @(posedge mclk);
    rd(8'h24);
    chk(32'h0, d, "fault");
    idle;
    wr(8'h14, 32'h0);
    repeat (2) @(posedge mclk);
    chk(32'h0, emergency_stop_brake_enable, "esbe_off");
    $display("t_brake done");
  endtask
  task t_fault;
    fb_bad <= 1'b1;
    repeat (200) @(posedge mclk);
    chk(32'h1, torque_removal, "tq_fault");
    rd(8'h24);
    chk(32'h1, d[0], "fault_b");
    fb_bad <= 1'b0;
    repeat (20) @(posedge mclk);
    wr(8'h24, 32'h1);
    repeat (4) @(posedge mclk);
    chk(32'h0, torque_removal, "tq_clr");
    $display("t_fault done");
  endtask
  task t_mis;
    spd(16'h0BB8);
    pins(1'b0, 1'b1);
    wt(1);
    chk(32'h1, emergency_decel_ramp, "ramp_mis");
    monitor_limit_hit <= 1'b1;
    @(posedge mclk);
    monitor_limit_hit <= 1'b0;
    wt(0);
    chk(32'h1, n <= 4, "tq_hit");
    rd(8'h24);
    chk(32'h1, d[1], "mis_bit");
    idle;
    wr(8'h24, 32'h2);
    $display("t_mis done");
  endtask
  initial begin
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    load <= 1'b0;
    repeat (3) @(posedge mclk);
    t_regs;
    t_time;
    t_ramp;
    t_brake;
    t_fault;
    t_mis;
    wrap_up;
  end
endmodule
bind sss_top sss_top_monitor #(.MS_TICK_CYCLES(MS_TICK_CYCLES))
  sss_top_monitor_i (.*);
`default_nettype wire
